// ===== core/tvsc_control_regs.sv
// apb register bank of the tv scaler with input timing measurement
// assumes all pin inputs asynchronous; apb from logic on clk
// Notes on behaviour
// - six-bit ratio code from software sets the horizontal stretch factor
// - select bit zero uses hardware ratio; one uses code and unity flag
// - shown pixels are capture size times sixteen times destination over source
// - divider is seven bits of sixteen pixels; override picks programmed count
// - sampled pixels per input line equal divider count times sixteen
// - zoom only: capture start shifts by signed seven-bit pan times eight
// - zoom only: capture start shifts by signed seven-bit pan times four lines
// - horizontal-only underscan acts only in hardware default mode
// - underscan select: one underscan, zero overscan and defaults off
// - input format field reports the connected input type
// - frame-store field reports external memory configuration
// - configuration bits report tv standard, subcarrier multiple, output type
// - input vertical total measured in units of four lines, read only
// - scan rate gives tv lines per input frame in units of four and input vsync level
// - tv status shows spare pins, address pin, blank, field, vsync
// - encoder control holds bars, monochrome, brightness and no-comb mode
// - display vertical start shifts by signed eight-bit offset times four
// - display horizontal start shifts by signed eight-bit offset times eight
// - misc bits seven to five equal 101 redirect two test pins
`timescale 1ns/1ps
`default_nettype none
module tvsc_control_regs
   import tvsc_pkg::*;
#(
   parameter int DEFAULT_RATIO = 0,
   parameter int DEFAULT_DIVIDER = 52
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // straps and pins
   input wire logic [7:0] hwConfigPins,
   input wire logic inputHsync,
   input wire logic inputVsync,
   input wire logic tvHsync,
   input wire logic [6:0] tvPins,
   input wire logic horizontalDataValidPin,
   input wire logic luma3,
   input wire logic luma2,
   input wire logic verticalDataValid,
   // scaler controls
   output tvsc_ctrl_type ctrl,
   output logic sparePinSix,
   output logic sparePinSeven,
   output logic horizontalDataValid
);
   // refuse defaults that the fields cannot hold
   if (DEFAULT_RATIO < 0 || DEFAULT_RATIO > 63 || DEFAULT_DIVIDER < 0 ||
       DEFAULT_DIVIDER > 127) begin : g_bad_default
      $error("tvsc_control_regs: default out of range");
   end
   localparam logic [5:0] DEF_RATIO = DEFAULT_RATIO[5:0];
   localparam logic [6:0] DEF_DIV = DEFAULT_DIVIDER[6:0];

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      logic [7:0] hRatio;
      logic [7:0] sampling_line_divider;
      logic [7:0] zhPan;
      logic [7:0] zvPan;
      logic [7:0] gProc;
      logic [7:0] memAssist;
      logic [7:0] encCtrl;
      logic [7:0] dvOff;
      logic [7:0] dhOff;
      logic [7:0] hold;
      logic [7:0] misc;
      logic [7:0] vDen;
      logic [7:0] vNum;
      logic [7:0] chroma;
      logic [7:0] hwCfg;
      logic [1:0] syncIn1;
      logic [1:0] syncIn2;
      logic [1:0] syncPrev;
      logic [7:0] pinS1;
      logic [7:0] pinS2;
      logic [3:0] miscS1;
      logic [3:0] miscS2;
      logic [9:0] hCount;
      logic [9:0] lineCount;
      logic [8:0] tvLineCount;
      logic [7:0] hTotal;
      logic [7:0] vTotal;
      logic [6:0] tv_lines_per_input_frame;
      logic [31:0] rdata;
      logic [7:0] hwS1;
      logic [7:0] hwS2;
      logic tvHsPrev;
      tvsc_ctrl_type ctrl;
      logic [2:0] pinsOut;
   } tvsc_state_type;

   tvsc_state_type st;
   tvsc_state_type next_st;

   function automatic logic [7:0] index_of(input logic [11:0] a);
      index_of = a[ADDR_LSB +: 8];
   endfunction : index_of

   function automatic logic signed [10:0] scaled(input logic [7:0] v, input int bits,
                                                 input int sh);
      logic signed [10:0] s;
      s = 11'sh000;
      if (bits == 7)
         s = {{4{v[6]}}, v[6:0]};
      else
         s = {{3{v[7]}}, v};
      scaled = s <<< sh;
   endfunction : scaled

   logic access;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic mapped;
   tvsc_tvpins_type tvIn;
   tvsc_hwcfg_type hw;
   logic [7:0] rdByte;

   assign access = psel && penable;
   assign idx = index_of(paddr);
   assign wbyte = pwdata[7:0];
   assign tvIn = st.pinS2[6:0];
   assign hw = st.hwCfg;

   // --------------------------------------------------------------
   // read decode
   // --------------------------------------------------------------
   always_comb begin
      mapped = 1'b1;
      rdByte = 8'h00;
      if (idx == IDX_HRATIO) begin
         rdByte = st.hRatio;
      end else if (idx == IDX_SAMPLING_LINE_DIVIDER) begin
         rdByte = st.sampling_line_divider;
      end else if (idx == IDX_ZHPAN) begin
         rdByte = st.zhPan;
      end else if (idx == IDX_ZVPAN) begin
         rdByte = st.zvPan;
      end else if (idx == IDX_GPROC) begin
         rdByte = st.gProc;
      end else if (idx == IDX_MEMAST) begin
         rdByte = st.memAssist;
      end else if (idx == IDX_HWCFG) begin
         rdByte = hw;
      end else if (idx == IDX_HTOT) begin
         rdByte = st.hTotal;
      end else if (idx == IDX_VTOT) begin
         rdByte = st.vTotal;
      end else if (idx == IDX_SCAN) begin
         rdByte = {st.syncIn2[1], st.tv_lines_per_input_frame};
      end else if (idx == IDX_TVST) begin
         rdByte = {tvIn.tvVsyncFlag, tvIn.tvFieldParity, tvIn.tvBlankFlag,
                   tvIn.busAddressSelectPin, 1'b0, tvIn.spareInputPins};
      end else if (idx == IDX_ENC) begin
         rdByte = st.encCtrl;
      end else if (idx == IDX_DVOFF) begin
         rdByte = st.dvOff;
      end else if (idx == IDX_DHOFF) begin
         rdByte = st.dhOff;
      end else if (idx == IDX_HOLD) begin
         rdByte = st.hold;
      end else if (idx == IDX_MISC) begin
         rdByte = st.misc;
      end else if (idx == IDX_VDEN) begin
         rdByte = st.vDen;
      end else if (idx == IDX_VNUM) begin
         rdByte = st.vNum;
      end else if (idx == IDX_CHROMA) begin
         rdByte = st.chroma;
      end else begin
         mapped = 1'b0;
      end
   end

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      next_st = st;
      // pin synchronisers
      next_st.syncIn1 = {inputVsync, inputHsync};
      next_st.syncIn2 = st.syncIn1;
      next_st.syncPrev = st.syncIn2;
      next_st.pinS1 = {tvHsync, tvPins};
      next_st.pinS2 = st.pinS1;
      next_st.miscS1 = {horizontalDataValidPin, luma3, luma2, verticalDataValid};
      next_st.miscS2 = st.miscS1;
      next_st.hwS1 = hwConfigPins;
      next_st.hwS2 = st.hwS1;
      next_st.tvHsPrev = st.pinS2[7];
      next_st.hwCfg = st.hwS2;
      // --------------------------------------------------------------
      // input timing measurement
      // --------------------------------------------------------------
      // sampled pixels between input hsyncs
      if (st.syncIn2[0] && !st.syncPrev[0]) begin
         next_st.hTotal = st.hCount[9:2];
         // the detecting cycle is the first of the next line
         next_st.hCount = 10'h001;
         next_st.lineCount = st.lineCount + 10'h001;
      end else if (st.hCount != 10'h3FF) begin
         next_st.hCount = st.hCount + 10'h001;
      end
      // tv line count on synchronised rising edges
      if (st.pinS2[7] && !st.tvHsPrev && st.tvLineCount != 9'h1FF) begin
         next_st.tvLineCount = st.tvLineCount + 9'h001;
      end
      if (st.syncIn2[1] && !st.syncPrev[1]) begin
         next_st.vTotal = st.lineCount[9:2];
         next_st.tv_lines_per_input_frame = st.tvLineCount[8:2];
         next_st.lineCount = 10'h000;
         next_st.tvLineCount = 9'h000;
      end
      // --------------------------------------------------------------
      // register writes at the access phase
      // --------------------------------------------------------------
      if (access && pwrite && pstrb[0]) begin
         if (idx == IDX_HRATIO) begin
            next_st.hRatio = wbyte & (RATIO_MASK | 8'hC0);
         end else if (idx == IDX_SAMPLING_LINE_DIVIDER) begin
            next_st.sampling_line_divider = wbyte;
         end else if (idx == IDX_ZHPAN) begin
            next_st.zhPan = wbyte & PAN_MASK;
         end else if (idx == IDX_ZVPAN) begin
            next_st.zvPan = wbyte & PAN_MASK;
         end else if (idx == IDX_GPROC) begin
            next_st.gProc = wbyte & (GPROC_MASK | 8'h87);
         end else if (idx == IDX_MEMAST) begin
            next_st.memAssist = wbyte;
         end else if (idx == IDX_ENC) begin
            next_st.encCtrl = wbyte & ENC_MASK;
         end else if (idx == IDX_DVOFF) begin
            next_st.dvOff = wbyte;
         end else if (idx == IDX_DHOFF) begin
            next_st.dhOff = wbyte;
         end else if (idx == IDX_HOLD) begin
            next_st.hold = wbyte & HOLD_MASK;
         end else if (idx == IDX_MISC) begin
            next_st.misc = wbyte;
         end else if (idx == IDX_VDEN) begin
            // six-bit ratio terms
            next_st.vDen = wbyte & RATIO_MASK;
         end else if (idx == IDX_VNUM) begin
            next_st.vNum = wbyte & RATIO_MASK;
         end else if (idx == IDX_CHROMA) begin
            next_st.chroma = wbyte & CHROMA_MASK;
         end
      end
      next_st.rdata = {24'h000000, rdByte};
      // --------------------------------------------------------------
      // effective controls
      // --------------------------------------------------------------
      // hardware or software ratio
      next_st.ctrl.softwareRatio = st.hRatio[RATIO_SEL_BIT];
      next_st.ctrl.horizontalRatioCode = st.hRatio[RATIO_SEL_BIT] ? st.hRatio[5:0] : DEF_RATIO;
      next_st.ctrl.unityRatio = st.hRatio[RATIO_SEL_BIT] && st.hRatio[RATIO_UNITY_BIT];
      next_st.ctrl.dividerOverride = st.sampling_line_divider[DIV_OVR_BIT];
      next_st.ctrl.samplingLineDivider = st.sampling_line_divider[DIV_OVR_BIT] ? st.sampling_line_divider[6:0] : DEF_DIV;
      next_st.ctrl.lineSamples = {next_st.ctrl.samplingLineDivider, 4'h0};
      next_st.ctrl.captureHDelta = st.gProc[MAGNIFY_BIT] ? scaled(st.zhPan, 7, SH8) : 11'sh000;
      next_st.ctrl.captureVDelta = st.gProc[MAGNIFY_BIT] ? scaled(st.zvPan, 7, SH4) : 11'sh000;
      next_st.ctrl.displayVDelta = scaled(st.dvOff, 8, SH4);
      next_st.ctrl.displayHDelta = scaled(st.dhOff, 8, SH8);
      // underscan x only in hardware mode
      next_st.ctrl.horizontalOnlyUnderscan = st.gProc[UDX_BIT] && !st.hRatio[RATIO_SEL_BIT];
      next_st.ctrl.underscanSelect = st.gProc[UDSEL_BIT];
      next_st.ctrl.magnifyEnable = st.gProc[MAGNIFY_BIT];
      next_st.ctrl.freezePicture = st.hold[FREEZE_BIT];
      next_st.ctrl.testPinRedirect = (st.misc[7:5] == TESTPIN_KEY);
      next_st.ctrl.encoderBits = st.encCtrl;
      next_st.ctrl.chromaBits = st.chroma;
      next_st.ctrl.verticalDen = st.vDen[5:0];
      next_st.ctrl.verticalNum = st.vNum[5:0];
      next_st.ctrl.memoryAssist = st.memAssist;
      if (next_st.ctrl.testPinRedirect)
         next_st.pinsOut = {st.miscS2[3], st.miscS2[0], 1'b0};
      else
         next_st.pinsOut = {1'b0, st.miscS2[1], st.miscS2[2]};
      // --------------------------------------------------------------
      // synchronous reset
      // --------------------------------------------------------------
      if (srst) begin
         next_st = '0;
         next_st.hRatio = RST_REG;
      end
   end

   always_ff @(posedge clk) begin
      st <= next_st;
   end

   // --------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = st.rdata;
   assign ctrl = st.ctrl;
   assign horizontalDataValid = st.pinsOut[2];
   // pins follow luma, or under redirect seven takes vertical data valid and six is held low
   assign sparePinSeven = st.pinsOut[1];
   assign sparePinSix = st.pinsOut[0];
endmodule : tvsc_control_regs
`default_nettype wire

// ===== core/tvsc_pkg.sv
// register map, field layouts and carrier types of the tv scaler control bank
// assumes an apb slave with byte addresses four times the printed register index
package tvsc_pkg;
   // register indices as printed
   localparam logic [7:0] IDX_HRATIO = 8'h27;
   localparam logic [7:0] IDX_SAMPLING_LINE_DIVIDER = 8'h28;
   localparam logic [7:0] IDX_ZHPAN = 8'h2B;
   localparam logic [7:0] IDX_ZVPAN = 8'h2C;
   localparam logic [7:0] IDX_GPROC = 8'h33;
   localparam logic [7:0] IDX_MEMAST = 8'h40;
   localparam logic [7:0] IDX_HWCFG = 8'h41;
   localparam logic [7:0] IDX_HTOT = 8'h42;
   localparam logic [7:0] IDX_VTOT = 8'h43;
   localparam logic [7:0] IDX_SCAN = 8'h44;
   localparam logic [7:0] IDX_TVST = 8'h45;
   localparam logic [7:0] IDX_ENC = 8'h50;
   localparam logic [7:0] IDX_DVOFF = 8'h51;
   localparam logic [7:0] IDX_DHOFF = 8'h52;
   localparam logic [7:0] IDX_HOLD = 8'h53;
   localparam logic [7:0] IDX_MISC = 8'h70;
   localparam logic [7:0] IDX_VDEN = 8'h71;
   localparam logic [7:0] IDX_VNUM = 8'h72;
   localparam logic [7:0] IDX_CHROMA = 8'h73;
   localparam int ADDR_LSB = 2;
   // reset values
   localparam logic [7:0] RST_REG = 8'h00;
   // field positions
   localparam int RATIO_SEL_BIT = 6;
   localparam int RATIO_UNITY_BIT = 7;
   localparam int DIV_OVR_BIT = 7;
   localparam int UDX_BIT = 3;
   localparam int UDSEL_BIT = 6;
   localparam int MAGNIFY_BIT = 7;
   localparam int FREEZE_BIT = 0;
   localparam logic [2:0] TESTPIN_KEY = 3'h5;
   localparam logic [7:0] ENC_MASK = 8'h3E;
   localparam logic [7:0] HOLD_MASK = 8'h01;
   localparam logic [7:0] RATIO_MASK = 8'h3F;
   localparam logic [7:0] PAN_MASK = 8'h7F;
   localparam logic [7:0] GPROC_MASK = 8'h4F;
   localparam logic [7:0] CHROMA_MASK = 8'h0C;
   // unit scales as shift counts: 16 pixels, 8 pixels, 4 lines
   localparam int SH16 = 4;
   localparam int SH8 = 3;
   localparam int SH4 = 2;
   // hardware configuration strap fields
   typedef struct packed {
      logic rgbOutputSelect;
      logic subcarrierClockMultiple;
      logic tvStandardSelect;
      logic memType;
      logic [1:0] frameStoreConfig;
      logic [1:0] inputFormat;
   } tvsc_hwcfg_type;
   // tv timing inputs
   typedef struct packed {
      logic tvVsyncFlag;
      logic tvFieldParity;
      logic tvBlankFlag;
      logic busAddressSelectPin;
      logic [2:0] spareInputPins;
   } tvsc_tvpins_type;
   // effective scaler controls for the datapath
   typedef struct packed {
      logic [5:0] horizontalRatioCode;
      logic softwareRatio;
      logic unityRatio;
      logic [6:0] samplingLineDivider;
      logic dividerOverride;
      logic [10:0] lineSamples;
      logic signed [10:0] captureHDelta;
      logic signed [10:0] captureVDelta;
      logic signed [10:0] displayHDelta;
      logic signed [10:0] displayVDelta;
      logic horizontalOnlyUnderscan;
      logic underscanSelect;
      logic magnifyEnable;
      logic freezePicture;
      logic testPinRedirect;
      logic [7:0] encoderBits;
      logic [7:0] chromaBits;
      logic [5:0] verticalDen;
      logic [5:0] verticalNum;
      logic [7:0] memoryAssist;
   } tvsc_ctrl_type;
endpackage : tvsc_pkg

// ===== test/tvsc_control_regs_props.sv
// checker for the tv scaler control bank
// assumes binding onto tvsc_control_regs and its apb port
`timescale 1ns/1ps
`default_nettype none
module tvsc_control_regs_props
   import tvsc_pkg::*;
#(
   parameter int DEFAULT_RATIO = 0,
   parameter int DEFAULT_DIVIDER = 52
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // controls
   input wire tvsc_ctrl_type ctrl
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ----------------
   // helpers
   // ----------------
   logic acc;
   logic hit;
   logic [7:0] d1;
   logic [7:0] w;
   assign acc = psel && penable;
   assign hit = paddr[9:2] inside {IDX_HRATIO, IDX_SAMPLING_LINE_DIVIDER, IDX_ZHPAN, IDX_ZVPAN, IDX_GPROC,
      IDX_MEMAST, IDX_HWCFG, IDX_HTOT, IDX_VTOT, IDX_SCAN, IDX_TVST, IDX_ENC, IDX_DVOFF,
      IDX_DHOFF, IDX_HOLD, IDX_MISC, IDX_VDEN, IDX_VNUM, IDX_CHROMA};
   // write data two edges back
   always_ff @(posedge clk) begin
      d1 <= pwdata[7:0];
      w <= d1;
   end
   sequence s_wr(logic [7:0] idx);
      acc && pwrite && pstrb[0] && paddr[9:2] == idx;
   endsequence
   sequence s_zoom(logic [7:0] idx);
      s_wr(idx) ##2 ctrl.magnifyEnable;
   endsequence
   // ----------------
   // assertions
   // ----------------
   chk_ready_access: assert property (acc |-> pready)
      else $error("no ready in access");
   chk_error_unmapped: assert property (pslverr == (acc && !hit))
      else $error("error flag wrong");
   chk_unmapped_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   chk_ratio_code: assert property (
      s_wr(IDX_HRATIO) |-> ##2 ctrl.softwareRatio == w[6]
      && ctrl.horizontalRatioCode == (w[6] ? w[5:0] : 6'(DEFAULT_RATIO)))
      else $error("ratio code wrong");
   chk_divider_count: assert property (
      s_wr(IDX_SAMPLING_LINE_DIVIDER) |-> ##2
      ctrl.lineSamples == (w[7] ? {w[6:0], 4'h0} : 11'(DEFAULT_DIVIDER * 16)))
      else $error("line samples wrong");
   chk_zoom_x: assert property (s_zoom(IDX_ZHPAN) |-> ctrl.captureHDelta == {w[6], w[6:0], 3'h0})
      else $error("zoom x pan wrong");
   chk_zoom_y: assert property (s_zoom(IDX_ZVPAN) |-> ctrl.captureVDelta == {{2{w[6]}}, w[6:0], 2'h0})
      else $error("zoom y pan wrong");
   chk_underscan_x: assert property (ctrl.softwareRatio |-> !ctrl.horizontalOnlyUnderscan)
      else $error("underscan x in software mode");
   chk_underscan_sel: assert property (s_wr(IDX_GPROC) |-> ##2 ctrl.underscanSelect == w[6])
      else $error("underscan select wrong");
   chk_encoder_bits: assert property (s_wr(IDX_ENC) |-> ##2 ctrl.encoderBits == (w & ENC_MASK))
      else $error("encoder bits wrong");
   chk_disp_vert: assert property (s_wr(IDX_DVOFF) |-> ##2 ctrl.displayVDelta == {w[7], w, 2'h0})
      else $error("display y offset wrong");
   chk_disp_horiz: assert property (s_wr(IDX_DHOFF) |-> ##2 ctrl.displayHDelta == {w, 3'h0})
      else $error("display x offset wrong");
   chk_freeze_bit: assert property (s_wr(IDX_HOLD) |-> ##2 ctrl.freezePicture == w[0])
      else $error("freeze bit wrong");
   chk_test_key: assert property (
      s_wr(IDX_MISC) |-> ##2 ctrl.testPinRedirect == (w[7:5] == TESTPIN_KEY))
      else $error("test pin key wrong");
endmodule : tvsc_control_regs_props
bind tvsc_control_regs tvsc_control_regs_props #(
   .DEFAULT_RATIO(DEFAULT_RATIO),
   .DEFAULT_DIVIDER(DEFAULT_DIVIDER)
) u_tvsc_control_regs_props (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .ctrl(ctrl)
);
`default_nettype wire

// ===== test/tb_tvsc_control_regs.sv
// self-checking bench for the tv scaler control bank
// assumes the package, the design and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_tvsc_control_regs;
   import tvsc_pkg::*;
   // ----------------
   // signals
   // ----------------
   localparam int DEF_RATIO = 9;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic inputHsync = 1'b0;
   logic inputVsync = 1'b0;
   logic tvHsync = 1'b0;
   logic [6:0] tvPins = 7'h00;
   logic hdvPin = 1'b0;
   logic luma3 = 1'b1;
   logic luma2 = 1'b0;
   logic vdv = 1'b0;
   // straps: two-field store, so freeze is allowed
   logic [7:0] hwPins = 8'hAB;
   tvsc_ctrl_type ctrl;
   logic sp6;
   logic sp7;
   logic hdv;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int checked = 0;
   logic [7:0] idxT [14] = '{IDX_HRATIO, IDX_SAMPLING_LINE_DIVIDER, IDX_ZHPAN, IDX_ZVPAN, IDX_GPROC, IDX_MEMAST,
      IDX_ENC, IDX_DVOFF, IDX_DHOFF, IDX_HOLD, IDX_MISC, IDX_VDEN, IDX_VNUM, IDX_CHROMA};
   logic [7:0] datT [14] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h81, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hA0, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] expT [14] = '{8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hCF, 8'h81, 8'h3E, 8'hFF, 8'hFF,
      8'h01, 8'hA0, 8'h3F, 8'h3F, 8'h0C};
   always #12.5 clk = ~clk;
   tvsc_control_regs #(.DEFAULT_RATIO(DEF_RATIO), .DEFAULT_DIVIDER(52)) u_tvsc_control_regs (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hwConfigPins(hwPins), .inputHsync(inputHsync), .inputVsync(inputVsync),
      .tvHsync(tvHsync), .tvPins(tvPins), .horizontalDataValidPin(hdvPin), .luma3(luma3),
      .luma2(luma2), .verticalDataValid(vdv), .ctrl(ctrl), .sparePinSix(sp6),
      .sparePinSeven(sp7), .horizontalDataValid(hdv)
   );
   // ----------------
   // tasks
   // ----------------
   task automatic end_of_test();
      if (fails == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // one apb transfer, request held until ready is sampled
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 8'h00);
      check(rd, exp);
   endtask : rdchk
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle
   // one input frame: vsync pulse, 40 lines, a tv line every second one
   task automatic frame();
      for (int i = 0; i < 41; i++) begin
         @(posedge clk);
         inputVsync <= (i == 0);
         inputHsync <= (i != 0);
         tvHsync <= (i != 0) && i[0];
         repeat (4) @(posedge clk);
         inputVsync <= 1'b0;
         inputHsync <= 1'b0;
         tvHsync <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask : frame
   // ----------------
   // scenarios
   // ----------------
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 14; i++) begin
         rdchk(idxT[i], 32'(RST_REG));
      end
      for (int i = 0; i < 14; i++) begin
         xfer(1'b1, idxT[i], datT[i]);
      end
      for (int i = 0; i < 14; i++) begin
         rdchk(idxT[i], {24'h0, expT[i]});
      end
      xfer(1'b1, IDX_HRATIO, 8'h05);
      xfer(1'b1, IDX_SAMPLING_LINE_DIVIDER, 8'h10);
      xfer(1'b1, IDX_GPROC, 8'h48);
      settle();
      check(32'({ctrl.softwareRatio, ctrl.horizontalOnlyUnderscan, ctrl.underscanSelect,
         ctrl.horizontalRatioCode, ctrl.lineSamples}), 32'({3'b011, 6'(DEF_RATIO), 11'h340}));
      xfer(1'b1, IDX_HRATIO, 8'h45);
      xfer(1'b1, IDX_SAMPLING_LINE_DIVIDER, 8'h81);
      settle();
      check(32'({ctrl.softwareRatio, ctrl.horizontalOnlyUnderscan, ctrl.horizontalRatioCode,
         ctrl.lineSamples}), 32'({2'b10, 6'h05, 11'h010}));
      xfer(1'b1, IDX_GPROC, 8'h80);
      xfer(1'b1, IDX_ZHPAN, 8'h7F);
      xfer(1'b1, IDX_ZVPAN, 8'h40);
      settle();
      check(32'({ctrl.magnifyEnable, ctrl.captureHDelta, ctrl.captureVDelta}),
         32'({1'b1, 11'h7F8, 11'h700}));
      xfer(1'b1, IDX_GPROC, 8'h00);
      settle();
      check(32'({ctrl.captureHDelta, ctrl.captureVDelta}), 32'h0);
      xfer(1'b1, IDX_DVOFF, 8'h80);
      xfer(1'b1, IDX_DHOFF, 8'h7F);
      settle();
      check(32'({ctrl.displayVDelta, ctrl.displayHDelta}), 32'({11'h600, 11'h3F8}));
      xfer(1'b1, IDX_MISC, 8'h00);
      hdvPin <= 1'b1;
      settle();
      check(32'({sp6, sp7}), 32'h2);
      xfer(1'b1, IDX_MISC, 8'hA0);
      settle();
      check(32'({hdv, sp7}), 32'h2);
      xfer(1'b1, IDX_MISC, 8'hE0);
      tvPins <= 7'h4D;
      inputVsync <= 1'b1;
      settle();
      check(32'({sp6, sp7}), 32'h2);
      rdchk(IDX_TVST, 32'h95);
      xfer(1'b0, IDX_SCAN, 8'h00);
      check(32'(rd[7]), 32'h1);
      rdchk(IDX_HWCFG, 32'hAB);
      xfer(1'b1, IDX_TVST, 8'hFF);
      rdchk(IDX_TVST, 32'h95);
      repeat (3) frame();
      rdchk(IDX_VTOT, 32'h0A);
      rdchk(IDX_HTOT, 32'h02);
      rdchk(IDX_SCAN, 32'h05);
      xfer(1'b0, 8'h30, 8'h00);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      end_of_test();
   end
endmodule : tb_tvsc_control_regs
`default_nettype wire
